// ---- verilog/clamp_coast_output_config_regs.sv ----
// Clamp, coast, output format and activity status register bank
`timescale 1ns/1ps
module clamp_coast_output_config_regs import disp_cfg_pkg::*; #(
  parameter int ACT_TO = ACT_TIMEOUT_CYC,
  parameter int LINE_W = 12
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire sync_in_t act_pins,
  input wire logic sep_vsync,
  input wire logic vsync_override,
  input wire logic vsync_source_sel,
  input wire logic if_override,
  input wire logic if_select,
  input wire pixel_t pix_in,
  input wire logic pix_in_valid,
  output pixel_t pix_out,
  output logic pix_out_valid,
  output logic [2:0] clamp_mid,
  output logic coast_pll,
  output logic coast_active_high,
  output logic [1:0] drive_strength,
  output logic analog_bw_wide,
  output logic out_clk_invert,
  output logic red_oe_n,
  output logic green_oe_n,
  output logic blue_oe_n,
  output logic sync_oe_n,
  output logic protect_addr_bit,
  output logic chip_sleep_ctrl_n,
  output logic format_422,
  output logic active_if,
  output logic seek_mode
);
  localparam int CW = $clog2(ACT_TO + 1);
  localparam logic [CW-1:0] ACT_LOAD = CW'(ACT_TO);

  logic [1:0] rst_q;
  logic rst_n;
  logic [7:0] ctl_r;
  logic [7:0] lead_r;
  logic [7:0] trail_r;
  logic [7:0] fmt_r;
  logic [3:0] pin_v;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] act_r;
  logic [CW-1:0] act_cnt [4];
  logic [7:0] stat;
  logic ai_nxt;
  logic vsel_nxt;
  logic vsel_r;
  logic vprev_r;
  logic h_rise;
  logic [LINE_W-1:0] lines_r;
  logic [LINE_W-1:0] frame_r;
  logic [7:0] post_r;
  logic pre;
  logic coast_raw;
  logic phase_r;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= CTL_RST;
      lead_r <= LEAD_RST;
      trail_r <= TRAIL_RST;
      fmt_r <= FMT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CTL: ctl_r <= reg_wdata & CTL_MASK;
        ADDR_LEAD: lead_r <= reg_wdata;
        ADDR_TRAIL: trail_r <= reg_wdata;
        ADDR_FMT: fmt_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads, answered one edge after the strobe
  assign stat = {act_r, active_if, 3'h0};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTL: reg_rdata <= ctl_r;
        ADDR_LEAD: reg_rdata <= lead_r;
        ADDR_TRAIL: reg_rdata <= trail_r;
        ADDR_FMT: reg_rdata <= fmt_r;
        ADDR_STAT: reg_rdata <= stat;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Activity detectors: bit 3 hsync, 2 green sync, 1 vsync, 0 link clock
  assign pin_v = act_pins;
  for (genvar i = 0; i < 4; i++) begin : g_act
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        act_cnt[i] <= '0;
        act_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= pin_v[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] != s3_r[i]) begin
          act_cnt[i] <= ACT_LOAD;
          act_r[i] <= 1'b1;
        end else if (act_cnt[i] != '0) begin
          act_cnt[i] <= act_cnt[i] - 1'b1;
        end else begin
          act_r[i] <= 1'b0;
        end
      end
    end
  end

  // Active interface choice
  always_comb begin
    if (if_override || (|act_r[3:1] && act_r[0])) begin
      ai_nxt = if_select;
    end else begin
      ai_nxt = act_r[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_if <= 1'b0;
      seek_mode <= 1'b0;
    end else begin
      active_if <= ai_nxt;
      seek_mode <= !if_override && !(|act_r);
    end
  end

  // Vertical sync source for coast
  always_comb begin
    if (vsync_override) begin
      vsel_nxt = vsync_source_sel ? sep_vsync : s2_r[1];
    end else begin
      vsel_nxt = act_r[1] ? s2_r[1] : sep_vsync;
    end
  end
  assign h_rise = s2_r[3] && !s3_r[3];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vsel_r <= 1'b0;
      vprev_r <= 1'b0;
    end else begin
      vsel_r <= vsel_nxt;
      vprev_r <= vsel_r;
    end
  end

  // Lines per frame, used to open coast ahead of vsync
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lines_r <= '0;
      frame_r <= '0;
    end else if (vsel_r && !vprev_r) begin
      frame_r <= lines_r;
      lines_r <= '0;
    end else if (h_rise && (lines_r != '1)) begin
      lines_r <= lines_r + 1'b1;
    end
  end
  assign pre = (frame_r != '0) && ((lines_r + LINE_W'(lead_r)) >= frame_r);

  // Hsync periods after vsync
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      post_r <= 8'h00;
    end else if (!vsel_r && vprev_r) begin
      post_r <= trail_r;
    end else if (h_rise && (post_r != 8'h00)) begin
      post_r <= post_r - 8'h01;
    end
  end
  assign coast_raw = vsel_r || pre || (post_r != 8'h00);

  // Coast to the PLL and its polarity
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coast_pll <= 1'b0;
      coast_active_high <= 1'b1;
    end else begin
      coast_pll <= ctl_r[CTL_COAST_EN] && coast_raw;
      if (!ctl_r[CTL_COAST_EN] && ctl_r[CTL_POL_OVR]) begin
        coast_active_high <= ctl_r[CTL_POL];
      end else begin
        coast_active_high <= 1'b1;
      end
    end
  end

  // Static controls
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clamp_mid <= 3'h0;
      drive_strength <= DRV_HIGH;
      analog_bw_wide <= 1'b1;
      out_clk_invert <= 1'b0;
      protect_addr_bit <= 1'b0;
      chip_sleep_ctrl_n <= 1'b1;
      format_422 <= 1'b0;
    end else begin
      clamp_mid <= ctl_r[CTL_CLAMP_LO +: 3];
      if (fmt_r[FMT_DRV_HI]) begin
        drive_strength <= DRV_HIGH;
      end else begin
        drive_strength <= fmt_r[FMT_DRV_LO] ? DRV_MED : DRV_LOW;
      end
      analog_bw_wide <= fmt_r[FMT_BW];
      out_clk_invert <= fmt_r[FMT_CLKINV] && active_if;
      protect_addr_bit <= fmt_r[FMT_ADDR];
      chip_sleep_ctrl_n <= fmt_r[FMT_PWR];
      format_422 <= fmt_r[FMT_422];
    end
  end

  // Output enables, low while driving
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      red_oe_n <= 1'b1;
      green_oe_n <= 1'b1;
      blue_oe_n <= 1'b1;
      sync_oe_n <= 1'b1;
    end else begin
      red_oe_n <= fmt_r[FMT_TRI];
      green_oe_n <= fmt_r[FMT_TRI];
      blue_oe_n <= fmt_r[FMT_TRI] || fmt_r[FMT_422];
      sync_oe_n <= fmt_r[FMT_TRI];
    end
  end

  // Pixel packing; 4:2:2 alternates chroma on red, blue first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pix_out <= '0;
      pix_out_valid <= 1'b0;
      phase_r <= 1'b0;
    end else begin
      pix_out_valid <= pix_in_valid;
      if (!pix_in_valid) begin
        phase_r <= 1'b0;
      end else if (fmt_r[FMT_422]) begin
        pix_out.g <= pix_in.g;
        pix_out.r <= phase_r ? pix_in.r : pix_in.b;
        pix_out.b <= 8'h00;
        phase_r <= !phase_r;
      end else begin
        pix_out <= pix_in;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_clamp_write: assert property (reg_wr && reg_addr == ADDR_CTL |->
    ##2 clamp_mid == $past(reg_wdata[6:4], 2)) else $error("clamp select not applied");
  a_coast_off: assert property (!ctl_r[CTL_COAST_EN] |=> !coast_pll)
    else $error("coast active while disabled");
  a_pol_internal: assert property (ctl_r[CTL_COAST_EN] |=> coast_active_high)
    else $error("override used with internal coast");
  a_pol_user: assert property (!ctl_r[CTL_COAST_EN] && ctl_r[CTL_POL_OVR] |=>
    coast_active_high == $past(ctl_r[CTL_POL])) else $error("user polarity ignored");
  a_pre_coast: assert property (pre && ctl_r[CTL_COAST_EN] |=> coast_pll)
    else $error("precoast not asserted");
  a_post_load: assert property ($fell(vsel_r) |=> post_r == $past(trail_r))
    else $error("postcoast count not loaded");
  a_drive_high: assert property (fmt_r[FMT_DRV_HI] |=> drive_strength == DRV_HIGH)
    else $error("drive not high");
  a_tri_all: assert property (fmt_r[FMT_TRI] |=>
    red_oe_n && green_oe_n && blue_oe_n && sync_oe_n) else $error("outputs driven");
  a_sleep_write: assert property (reg_wr && reg_addr == ADDR_FMT |->
    ##2 chip_sleep_ctrl_n == $past(reg_wdata[1], 2)) else $error("power bit lost");
  a_blue_float: assert property (fmt_r[FMT_422] |=> blue_oe_n)
    else $error("blue driven in 4:2:2");
  a_hs_hold: assert property (s2_r[3] != s3_r[3] |=> act_r[3] [*8])
    else $error("hsync activity dropped early");
  a_act_clear: assert property (act_cnt[1] == '0 && s2_r[1] == s3_r[1] |=>
    !act_r[1]) else $error("vsync activity not cleared");
  a_ai_force: assert property (if_override |=> active_if == $past(if_select))
    else $error("interface override ignored");

  c_precoast: cover property (pre && ctl_r[CTL_COAST_EN] ##1 coast_pll);
  c_pack_422: cover property (format_422 && pix_out_valid [*4]);
  c_link_seen: cover property ($rose(active_if));
  c_act_lost: cover property ($fell(act_r[3]));
endmodule // clamp_coast_output_config_regs

// ---- pkg/disp_cfg_pkg.sv ----
// Constants and types for the clamp, coast and output configuration bank
// Summary of operation
// - Red, green, blue clamp bits pick ground (0) or midscale (1); reset 0.
// - Coast enable resets 1; enabled coast uses the selected vertical sync source.
// - Polarity override resets 0; user polarity applies only while coast disabled.
// - Coast polarity resets 1; 0 active low, 1 active high, honored when overridden.
// - Precoast count, reset 0, asserts coast that many hsync edges before vsync.
// - Postcoast count, reset 0, extends coast that many hsync periods after vsync.
// - Drive field: bit 7 high gives high, 01 medium, 00 low; reset 11.
// - Bandwidth bit picks 10 MHz (0) or 300 MHz (1) front end.
// - Clock invert, reset 0, acts only in digital interface mode.
// - Three-state bit, reset 0, floats red, green, blue and sync outputs.
// - Bit 2 gives the protection slave address bit; reset 0.
// - Power bit active low: 0 power-down, 1 normal; reset 1.
// - Format bit picks 4:4:4 (0) or 4:2:2 (1), 16 data lines.
// - In 4:2:2 green carries luma, red alternates chroma, blue floats.
// - Status bit 7 shows hsync transitions; 0 when static.
// - Status bit 6 shows sync-on-green activity, video may set it.
// - Status bit 5 shows vsync transitions; 0 when static.
// - Status bit 4 shows digital link clock activity.
// - Analog detect is OR of bits 7..5; digital detect is bit 4.
// - With vsync override, select 0 takes vsync pin, 1 sync separator.
package disp_cfg_pkg;
  localparam logic [7:0] ADDR_CTL = 8'h11;
  localparam logic [7:0] ADDR_LEAD = 8'h12;
  localparam logic [7:0] ADDR_TRAIL = 8'h13;
  localparam logic [7:0] ADDR_FMT = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h15;
  localparam int CTL_CLAMP_LO = 4;
  localparam int CTL_COAST_EN = 3;
  localparam int CTL_POL_OVR = 2;
  localparam int CTL_POL = 1;
  localparam int FMT_DRV_HI = 7;
  localparam int FMT_DRV_LO = 6;
  localparam int FMT_BW = 5;
  localparam int FMT_CLKINV = 4;
  localparam int FMT_TRI = 3;
  localparam int FMT_ADDR = 2;
  localparam int FMT_PWR = 1;
  localparam int FMT_422 = 0;
  localparam logic [7:0] CTL_RST = 8'h0A;
  localparam logic [7:0] CTL_MASK = 8'hFE;
  localparam logic [7:0] LEAD_RST = 8'h00;
  localparam logic [7:0] TRAIL_RST = 8'h00;
  localparam logic [7:0] FMT_RST = 8'hE2;
  localparam logic [1:0] DRV_LOW = 2'h0;
  localparam logic [1:0] DRV_MED = 2'h1;
  localparam logic [1:0] DRV_HIGH = 2'h2;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACT_TIMEOUT_NS = 100000;
  localparam int ACT_TIMEOUT_CYC = ACT_TIMEOUT_NS / CLK_PERIOD_NS;
  typedef struct packed {
    logic hsync;
    logic green_embedded_sync;
    logic vsync;
    logic link_clk;
  } sync_in_t;
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pixel_t;
endpackage

// ---- testbench/ctrl_model.sv ----
// Register port driver standing in for the system controller
`timescale 1ns/1ps
module ctrl_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
  // Coast off: enable low, override and polarity high
  task automatic coast_off(input logic [2:0] clamp);
    wr(8'h11, {1'b0, clamp, 4'h6});
  endtask
  // Ground clamps for RGB; luma ground, chroma midscale for YPbPr
  function automatic logic [2:0] clamp_for(input logic ypbpr);
    return ypbpr ? 3'h5 : 3'h0;
  endfunction
endmodule // ctrl_model

// ---- testbench/clamp_coast_output_config_regs_tb.sv ----
// Self-checking bench for the clamp, coast and output register bank
`timescale 1ns/1ps
module clamp_coast_output_config_regs_tb import disp_cfg_pkg::*;;
  logic clk_sys = 1'b0, resetn = 1'b0, sep_vsync = 1'b0, vs_ovr = 1'b0, if_sel = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, c, f;
  logic reg_wr, reg_rd, pix_valid = 1'b0;
  sync_in_t act = '0;
  pixel_t pix_in = '0, pix_out;
  logic [2:0] clamp_mid;
  logic [1:0] drive_strength;
  logic cah, bw, oci, r_oe, g_oe, b_oe, s_oe, pab, sleep_n, f422;
  logic if_ovr = 1'b1, pv, cp, ai, sm;
  pixel_t p;
  int err_count = 0, n_tests = 0;
  wire [7:0] st = {clamp_mid, drive_strength, bw, sleep_n, f422};
  wire [7:0] st2 = {pab, cah, oci, 1'b0, s_oe, r_oe, g_oe, b_oe};
  always #50 clk_sys = ~clk_sys;
  ctrl_model i_ctrl_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  clamp_coast_output_config_regs #(.ACT_TO(16)) i_clamp_coast_output_config_regs (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .act_pins(act),
    .sep_vsync(sep_vsync), .vsync_override(vs_ovr), .vsync_source_sel(sep_vsync),
    .if_override(if_ovr), .if_select(if_sel), .pix_in(pix_in), .pix_in_valid(pix_valid),
    .pix_out(pix_out), .pix_out_valid(pv), .clamp_mid(clamp_mid), .coast_pll(cp),
    .coast_active_high(cah), .drive_strength(drive_strength), .analog_bw_wide(bw),
    .out_clk_invert(oci), .red_oe_n(r_oe), .green_oe_n(g_oe), .blue_oe_n(b_oe),
    .sync_oe_n(s_oe), .protect_addr_bit(pab), .chip_sleep_ctrl_n(sleep_n),
    .format_422(f422), .active_if(ai), .seek_mode(sm));
  function automatic logic [7:0] e_st(input logic [7:0] c, input logic [7:0] f);
    return {c[6:4], f[7] ? DRV_HIGH : (f[6] ? DRV_MED : DRV_LOW), f[5], f[1], f[0]};
  endfunction
  function automatic logic [7:0] e_st2(input logic [7:0] c, input logic [7:0] f);
    return {f[2], (!c[3] && c[2]) ? c[1] : 1'b1, 2'h0, {3{f[3]}}, f[3] | f[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_ctrl_model.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    #1;
    pix_in <= pixel_t'($urandom);
  end
  initial begin
    #(100 * 20000);
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hA5EE));
    repeat (2) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("reset outs", e_st(CTL_RST, FMT_RST), st);
    chk("reset outs2", e_st2(CTL_RST, FMT_RST), st2);
    rchk(ADDR_CTL, CTL_RST);
    rchk(ADDR_LEAD, LEAD_RST);
    rchk(ADDR_TRAIL, TRAIL_RST);
    rchk(ADDR_FMT, FMT_RST);
    rchk(8'h10, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      c = (i == 0) ? {1'b0, i_ctrl_model.clamp_for(1'b1), 4'h2} : $urandom;
      f = (i == 1) ? 8'h49 : ((i == 2) ? 8'h00 : $urandom);
      d = $urandom;
      i_ctrl_model.wr(ADDR_CTL, c);
      i_ctrl_model.wr(ADDR_FMT, f);
      i_ctrl_model.wr(ADDR_LEAD, d);
      i_ctrl_model.wr(ADDR_TRAIL, ~d);
      i_ctrl_model.wr(ADDR_STAT, d);
      settle();
      chk("outs", e_st(c, f), st);
      chk("outs2", e_st2(c, f), st2);
      rchk(ADDR_CTL, c & CTL_MASK);
      rchk(ADDR_LEAD, d);
      rchk(ADDR_TRAIL, ~d);
      rchk(ADDR_STAT, 8'h00);
    end
    $display("register test done");
    i_ctrl_model.coast_off(3'h0);
    settle();
    chk("coast off pol", 8'h01, {7'h0, cah});
    chk("coast off pll", 8'h00, {7'h0, cp});
    i_ctrl_model.wr(ADDR_CTL, 8'h04);
    settle();
    chk("coast low pol", 8'h00, {7'h0, cah});
    i_ctrl_model.wr(ADDR_FMT, 8'h10);
    if_sel = 1'b1;
    settle();
    chk("clk inv digital", 8'h01, {7'h0, oci});
    if_sel = 1'b0;
    $display("coast and clock test done");
    i_ctrl_model.wr(ADDR_FMT, 8'h01);
    settle();
    pix_valid = 1'b1;
    @(negedge clk_sys);
    p = pix_in;
    @(posedge clk_sys);
    #1;
    chk("pix g", p.g, pix_out.g);
    chk("pix r first", p.b, pix_out.r);
    chk("pix b", 8'h00, pix_out.b);
    chk("pix valid", 8'h01, {7'h0, pv});
    @(negedge clk_sys);
    p = pix_in;
    @(posedge clk_sys);
    #1;
    chk("pix r second", p.r, pix_out.r);
    pix_valid = 1'b0;
    $display("pixel test done");
    if_ovr = 1'b0;
    for (int i = 0; i < 4; i++) begin
      repeat (10) begin
        @(posedge clk_sys);
        #1;
        act[3 - i] = ~act[3 - i];
      end
      rchk(ADDR_STAT, (8'h80 >> i) | ((i == 3) ? 8'h08 : 8'h00));
      repeat (30) @(posedge clk_sys);
      rchk(ADDR_STAT, 8'h00);
      chk("seek mode", 8'h01, {7'h0, sm});
    end
    $display("activity test done");
    wrap_up();
  end
endmodule // clamp_coast_output_config_regs_tb
